/* File: self_check_pkg.sv */
package self_check_pkg;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [15:0] VERIFY_OPCODE = 16'h00c9;
   localparam logic [15:0] TRAP_ENABLE_OPCODE = 16'h0109;
   localparam logic [15:0] TRAP_INHIBIT_OPCODE = 16'h010b;

   // ------------------------------------------------------------
   // recovery interrupt and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RECOVERY_VECTOR = 16'h0038;
   localparam logic MC_ENABLE_RESET = 1'b1;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // ------------------------------------------------------------
   // test table shape
   // ------------------------------------------------------------
   localparam int TEST_ID_W = 8;
   localparam int TEST_COUNT = 8;
   localparam int KIND_W = 3;

   typedef enum logic [2:0] {
      CHECK_CPU_LOGIC,
      CHECK_DATA_REGS,
      CHECK_IO_ADDR,
      CHECK_IO_DATA,
      CHECK_MEM_ADDR,
      CHECK_MEM_DATA,
      CHECK_REG_FILE,
      CHECK_DETECTOR
   } check_kind_type;

   typedef enum logic [1:0] {
      ENTRY_NONE,
      ENTRY_PANEL,
      ENTRY_MCHECK,
      ENTRY_INSTR
   } entry_type;

   // test id to the resource it exercises, fixed in control logic
   function automatic check_kind_type kind_of(input logic [KIND_W-1:0] id);
      return check_kind_type'(id);
   endfunction

endpackage

/* File: check_stepper.sv */
`timescale 1ns/1ps
module check_stepper #(
   parameter int TEST_COUNT = self_check_pkg::TEST_COUNT,
   parameter int ID_W = self_check_pkg::TEST_ID_W
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic pass_start_in,
   input wire logic test_done_in,
   input wire logic test_fail_in,
   input wire logic detector_flag_in,
   output logic test_start_out,
   output logic [ID_W-1:0] test_id_out,
   output logic inject_out,
   output logic pass_done_out,
   output logic pass_fail_out,
   output logic [ID_W-1:0] fail_id_out
);

   typedef enum {STEP_IDLE, STEP_ISSUE, STEP_WAIT} step_state_type;

   localparam logic [ID_W-1:0] LAST_ID = ID_W'(TEST_COUNT - 1);
   localparam logic [ID_W-1:0] ID_ZERO = '0;
   localparam logic [ID_W-1:0] ID_ONE = ID_W'(1);

   step_state_type state_q, state_d;
   logic [ID_W-1:0] id_q, id_d, fail_id_q, fail_id_d;
   logic any_fail_q, any_fail_d, done_q, done_d, inject_q, inject_d;
   logic step_fail;

   // ------------------------------------------------------------
   // walk the test table one test at a time
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      id_d = id_q;
      fail_id_d = fail_id_q;
      any_fail_d = any_fail_q;
      inject_d = inject_q;
      done_d = 1'b0;
      // injection tests pass only when the detector catches the fault
      step_fail = inject_q ? !detector_flag_in : test_fail_in;
      case (state_q)
         STEP_IDLE: begin
         end
         STEP_ISSUE: begin
            inject_d = (self_check_pkg::kind_of(id_q[self_check_pkg::KIND_W-1:0])
                        == self_check_pkg::CHECK_DETECTOR);
            state_d = STEP_WAIT;
         end
         STEP_WAIT: begin
            if (test_done_in) begin
               if (step_fail && !any_fail_q) begin
                  fail_id_d = id_q;
               end
               any_fail_d = any_fail_q | step_fail;
               inject_d = 1'b0;
               if (id_q == LAST_ID) begin
                  done_d = 1'b1;
                  state_d = STEP_IDLE;
               end else begin
                  id_d = id_q + ID_ONE;
                  state_d = STEP_ISSUE;
               end
            end
         end
         default: begin
            state_d = STEP_IDLE;
         end
      endcase
      if (pass_start_in) begin
         id_d = ID_ZERO;
         any_fail_d = 1'b0;
         fail_id_d = ID_ZERO;
         inject_d = 1'b0;
         done_d = 1'b0;
         state_d = STEP_ISSUE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= STEP_IDLE;
         id_q <= ID_ZERO;
         fail_id_q <= ID_ZERO;
         any_fail_q <= 1'b0;
         done_q <= 1'b0;
         inject_q <= 1'b0;
      end else begin
         state_q <= state_d;
         id_q <= id_d;
         fail_id_q <= fail_id_d;
         any_fail_q <= any_fail_d;
         done_q <= done_d;
         inject_q <= inject_d;
      end
   end

   assign test_start_out = (state_q == STEP_ISSUE);
   assign test_id_out = id_q;
   assign inject_out = inject_q;
   assign pass_done_out = done_q;
   assign pass_fail_out = any_fail_q;
   assign fail_id_out = fail_id_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_INJECT_DETECTOR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (test_start_out && test_id_out[self_check_pkg::KIND_W-1:0] == 3'h7 && !pass_start_in)
      |=> inject_out)
      else $error("detector test issued without fault injection");

   AST_STEP_ADVANCE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (state_q == STEP_WAIT && test_done_in && id_q != LAST_ID && !pass_start_in)
      |=> test_start_out && test_id_out == $past(test_id_out) + ID_ONE)
      else $error("test sequence did not advance to next test");

endmodule

/* File: self_verify_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - start on panel clear, machine check, verify
// - two instructions set and clear check trigger
// - error present keeps normal processing halted, except during a verify instruction
// - transient error resumes on its own
// - clean pass after a failure clears keys, file, interrupts '70
// - solid failure reruns checks forever
// - failing test number shown on lamps
// - verify failure loads test number into A
// - verify all passing skips next instruction
// - without microcode, verify is a no-op
// - checks cover CPU, registers, buses, file
// - injected faults must trip the detectors
// - sequence lives in control store only
module self_verify_ctrl #(
   parameter bit HAS_VERIFY = 1'b1,
   parameter int TEST_COUNT = self_check_pkg::TEST_COUNT,
   parameter int ID_W = self_check_pkg::TEST_ID_W
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic panel_clear_in,
   input wire logic machine_check_in,
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_word_in,
   input wire logic test_done_in,
   input wire logic test_fail_in,
   input wire logic detector_flag_in,
   output logic test_start_out,
   output logic [ID_W-1:0] test_id_out,
   output logic inject_out,
   output logic halt_out,
   output logic instr_done_out,
   output logic skip_out,
   output logic acc_load_out,
   output logic [15:0] acc_data_out,
   output logic [15:0] panel_lamps_out,
   output logic clear_keys_out,
   output logic clear_regfile_out,
   output logic irq_out,
   output logic [15:0] irq_vector_out,
   output logic mc_enable_out
);

   typedef enum {SEQ_IDLE, SEQ_START, SEQ_WAIT, SEQ_RECOVER} seq_state_type;

   seq_state_type state_q, state_d;
   self_check_pkg::entry_type entry_q, entry_d;
   logic mc_enable_q, mc_enable_d, mc_prev_q;
   logic failed_seen_q, failed_seen_d;
   logic done_q, done_d, skip_q, skip_d, acc_load_q, acc_load_d;
   logic [15:0] acc_data_q, acc_data_d, lamps_q, lamps_d;
   logic clr_q, clr_d, irq_q, irq_d;
   logic pass_done, pass_fail;
   logic [ID_W-1:0] fail_id;
   logic is_verify, is_enable, is_inhibit, mc_rise, run_bad;

   // ------------------------------------------------------------
   // instruction decode and trigger detection
   // ------------------------------------------------------------
   assign is_verify = instr_valid_in && instr_word_in == self_check_pkg::VERIFY_OPCODE;
   assign is_enable = instr_valid_in && instr_word_in == self_check_pkg::TRAP_ENABLE_OPCODE;
   assign is_inhibit = instr_valid_in && instr_word_in == self_check_pkg::TRAP_INHIBIT_OPCODE;
   assign mc_rise = machine_check_in && !mc_prev_q;
   // a pass with the error still standing counts as a failure
   assign run_bad = pass_fail || machine_check_in;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      entry_d = entry_q;
      mc_enable_d = mc_enable_q;
      failed_seen_d = failed_seen_q;
      acc_data_d = acc_data_q;
      lamps_d = lamps_q;
      done_d = 1'b0;
      skip_d = 1'b0;
      acc_load_d = 1'b0;
      clr_d = 1'b0;
      irq_d = 1'b0;
      case (state_q)
         SEQ_IDLE: begin
            if (mc_rise && mc_enable_q) begin
               entry_d = self_check_pkg::ENTRY_MCHECK;
               failed_seen_d = 1'b1;
               state_d = SEQ_START;
            end else if (is_verify) begin
               if (HAS_VERIFY) begin
                  entry_d = self_check_pkg::ENTRY_INSTR;
                  state_d = SEQ_START;
               end else begin
                  done_d = 1'b1;
               end
            end else if (is_enable) begin
               mc_enable_d = 1'b1;
               done_d = 1'b1;
            end else if (is_inhibit) begin
               mc_enable_d = 1'b0;
               done_d = 1'b1;
            end
         end
         SEQ_START: begin
            state_d = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (pass_done) begin
               if (entry_q == self_check_pkg::ENTRY_INSTR) begin
                  done_d = 1'b1;
                  state_d = SEQ_IDLE;
                  entry_d = self_check_pkg::ENTRY_NONE;
                  if (pass_fail) begin
                     acc_load_d = 1'b1;
                     acc_data_d = 16'(fail_id);
                  end else begin
                     skip_d = 1'b1;
                  end
               end else if (run_bad) begin
                  failed_seen_d = 1'b1;
                  if (pass_fail) begin
                     lamps_d = 16'(fail_id);
                  end
                  state_d = SEQ_START;
               end else if (failed_seen_q) begin
                  clr_d = 1'b1;
                  state_d = SEQ_RECOVER;
               end else begin
                  state_d = SEQ_IDLE;
                  entry_d = self_check_pkg::ENTRY_NONE;
               end
            end
         end
         SEQ_RECOVER: begin
            irq_d = 1'b1;
            failed_seen_d = 1'b0;
            entry_d = self_check_pkg::ENTRY_NONE;
            state_d = SEQ_IDLE;
         end
         default: begin
            state_d = SEQ_IDLE;
         end
      endcase
      if (panel_clear_in) begin
         entry_d = self_check_pkg::ENTRY_PANEL;
         state_d = SEQ_START;
         done_d = 1'b0;
         skip_d = 1'b0;
         acc_load_d = 1'b0;
         clr_d = 1'b0;
         irq_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= SEQ_IDLE;
         entry_q <= self_check_pkg::ENTRY_NONE;
         mc_enable_q <= self_check_pkg::MC_ENABLE_RESET;
         mc_prev_q <= 1'b0;
         failed_seen_q <= 1'b0;
         done_q <= 1'b0;
         skip_q <= 1'b0;
         acc_load_q <= 1'b0;
         acc_data_q <= self_check_pkg::WORD_ZERO;
         lamps_q <= self_check_pkg::WORD_ZERO;
         clr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         entry_q <= entry_d;
         mc_enable_q <= mc_enable_d;
         mc_prev_q <= machine_check_in;
         failed_seen_q <= failed_seen_d;
         done_q <= done_d;
         skip_q <= skip_d;
         acc_load_q <= acc_load_d;
         acc_data_q <= acc_data_d;
         lamps_q <= lamps_d;
         clr_q <= clr_d;
         irq_q <= irq_d;
      end
   end

   // ------------------------------------------------------------
   // test walker; its table is fixed logic, no memory fetches
   // ------------------------------------------------------------
   check_stepper #(
      .TEST_COUNT(TEST_COUNT),
      .ID_W(ID_W)
   ) u_stepper (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pass_start_in(state_q == SEQ_START),
      .test_done_in(test_done_in),
      .test_fail_in(test_fail_in),
      .detector_flag_in(detector_flag_in),
      .test_start_out(test_start_out),
      .test_id_out(test_id_out),
      .inject_out(inject_out),
      .pass_done_out(pass_done),
      .pass_fail_out(pass_fail),
      .fail_id_out(fail_id)
   );

   assign halt_out = (state_q != SEQ_IDLE);
   assign instr_done_out = done_q;
   assign skip_out = skip_q;
   assign acc_load_out = acc_load_q;
   assign acc_data_out = acc_data_q;
   assign panel_lamps_out = lamps_q;
   assign clear_keys_out = clr_q;
   assign clear_regfile_out = clr_q;
   assign irq_out = irq_q;
   assign irq_vector_out = self_check_pkg::RECOVERY_VECTOR;
   assign mc_enable_out = mc_enable_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   AST_PANEL_START: assert property (panel_clear_in |=> halt_out ##1 test_start_out)
      else $error("panel clear did not start verification");

   AST_TRAP_ENABLE: assert property ((state_q == SEQ_IDLE && is_enable && !panel_clear_in &&
      !(mc_rise && mc_enable_q)) |=> mc_enable_out && instr_done_out && !halt_out)
      else $error("enable instruction did not set trap enable");

   AST_TRAP_INHIBIT: assert property ((state_q == SEQ_IDLE && mc_rise && !mc_enable_q &&
      !panel_clear_in && !instr_valid_in) |=> !halt_out)
      else $error("machine check started verification while inhibited");

   AST_HALT_WHILE_ERROR: assert property ((halt_out && machine_check_in &&
      entry_q != self_check_pkg::ENTRY_INSTR) |=> halt_out)
      else $error("processing resumed with error present");

   AST_RERUN: assert property ((state_q == SEQ_WAIT && pass_done && run_bad &&
      entry_q != self_check_pkg::ENTRY_INSTR && !panel_clear_in) |=> halt_out ##1 test_start_out)
      else $error("solid failure did not rerun checks");

   AST_LAMPS: assert property ((state_q == SEQ_WAIT && pass_done && pass_fail &&
      entry_q != self_check_pkg::ENTRY_INSTR && !panel_clear_in) |=> panel_lamps_out == 16'($past(fail_id)))
      else $error("failing test not shown on lamps");

   AST_RECOVER_ORDER: assert property (clear_keys_out |-> clear_regfile_out ##1
      (irq_out && irq_vector_out == self_check_pkg::RECOVERY_VECTOR && !halt_out))
      else $error("recovery clear not followed by interrupt");

   AST_VERIFY_FAIL: assert property ((state_q == SEQ_WAIT && pass_done && pass_fail &&
      entry_q == self_check_pkg::ENTRY_INSTR && !panel_clear_in)
      |=> acc_load_out && instr_done_out && !skip_out && acc_data_out == 16'($past(fail_id)))
      else $error("verify failure did not load test number");

   AST_VERIFY_PASS: assert property (skip_out |-> instr_done_out && !acc_load_out && !halt_out)
      else $error("skip without clean verify completion");

   AST_VERIFY_NOOP: assert property ((!HAS_VERIFY && state_q == SEQ_IDLE && is_verify &&
      !panel_clear_in && !(mc_rise && mc_enable_q)) |=> instr_done_out && !skip_out && !acc_load_out && !halt_out)
      else $error("verify not treated as no-op without microcode");

   AST_VERIFY_DECODE: assert property ((HAS_VERIFY && state_q == SEQ_IDLE && is_verify &&
      !panel_clear_in && !(mc_rise && mc_enable_q)) |=> halt_out)
      else $error("verify opcode not recognised");

   COV_RECOVERY: cover property (clear_keys_out ##1 irq_out);
   COV_SKIP: cover property (skip_out);
   COV_ACC_LOAD: cover property (acc_load_out);
   COV_RERUN: cover property (state_q == SEQ_WAIT && pass_done && run_bad ##1 state_q == SEQ_START);

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic panel_clear_in = 1'b0;
   logic machine_check_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic [15:0] instr_word_in = 16'h0000;
   logic test_done_in = 1'b0;
   logic test_fail_in = 1'b0;
   logic detector_flag_in = 1'b0;
   logic test_start_out, inject_out, halt_out, instr_done_out, skip_out, acc_load_out;
   logic clear_keys_out, clear_regfile_out, irq_out, mc_enable_out;
   logic [7:0] test_id_out;
   logic [15:0] acc_data_out, panel_lamps_out, irq_vector_out;
   logic nv_halt, nv_done, nv_skip, nv_acc;
   int miscompares = 0;
   int checked = 0;

   self_verify_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .panel_clear_in(panel_clear_in),
      .machine_check_in(machine_check_in), .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
      .test_done_in(test_done_in), .test_fail_in(test_fail_in), .detector_flag_in(detector_flag_in),
      .test_start_out(test_start_out), .test_id_out(test_id_out), .inject_out(inject_out),
      .halt_out(halt_out), .instr_done_out(instr_done_out), .skip_out(skip_out),
      .acc_load_out(acc_load_out), .acc_data_out(acc_data_out), .panel_lamps_out(panel_lamps_out),
      .clear_keys_out(clear_keys_out), .clear_regfile_out(clear_regfile_out), .irq_out(irq_out),
      .irq_vector_out(irq_vector_out), .mc_enable_out(mc_enable_out));

   // variant without the check microcode
   self_verify_ctrl #(.HAS_VERIFY(1'b0)) dut_nv (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .panel_clear_in(panel_clear_in), .machine_check_in(machine_check_in),
      .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in), .test_done_in(test_done_in),
      .test_fail_in(test_fail_in), .detector_flag_in(detector_flag_in), .test_start_out(),
      .test_id_out(), .inject_out(), .halt_out(nv_halt), .instr_done_out(nv_done),
      .skip_out(nv_skip), .acc_load_out(nv_acc), .acc_data_out(), .panel_lamps_out(),
      .clear_keys_out(), .clear_regfile_out(), .irq_out(), .irq_vector_out(), .mc_enable_out());

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task give_verdict;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   function logic sig(input int k);
      case (k)
         0: return test_start_out;
         1: return instr_done_out;
         2: return clear_keys_out;
         3: return !halt_out;
         4: return nv_done;
         default: return halt_out;
      endcase
   endfunction

   // bounded wait, checked at falling edges
   task wait_sig(input int k);
      int n;
      for (n = 0; n < 100 && sig(k) !== 1'b1; n++) @(negedge clk_in);
      if (sig(k) !== 1'b1) begin
         miscompares++;
         $display("MISMATCH wait code %0d expected 1 seen 0", k);
         give_verdict();
      end
   endtask

   task issue(input logic [15:0] w);
      instr_valid_in = 1'b1;
      instr_word_in = w;
      @(negedge clk_in);
      instr_valid_in = 1'b0;
   endtask

   task pulse_panel;
      panel_clear_in = 1'b1;
      @(negedge clk_in);
      panel_clear_in = 1'b0;
   endtask

   // answers one full pass; fail_at 8 means no test fails unless det is 0
   task do_pass(input int fail_at, input logic det, input logic seen);
      int i;
      for (i = 0; i < 8; i++) begin
         if (!(seen && i == 0)) wait_sig(0);
         chk("test_id", 16'(i), 16'(test_id_out));
         @(negedge clk_in);
         chk("inject", 16'(i == 7), 16'(inject_out));
         test_done_in = 1'b1;
         test_fail_in = (i == fail_at) && (i != 7);
         detector_flag_in = det;
         @(negedge clk_in);
         test_done_in = 1'b0;
         test_fail_in = 1'b0;
         detector_flag_in = 1'b0;
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task sc_reset;
      chk("mc_enable", 16'h0001, 16'(mc_enable_out));
      chk("irq_vector", 16'h0038, irq_vector_out);
      chk("halt", 16'h0000, 16'(halt_out));
      chk("lamps", 16'h0000, panel_lamps_out);
   endtask

   task sc_verify(input int fail_at, input logic det, input logic [15:0] exp_id);
      issue(self_check_pkg::VERIFY_OPCODE);
      wait_sig(5);
      do_pass(fail_at, det, 1'b0);
      wait_sig(1);
      chk("skip", 16'(exp_id == 16'hffff), 16'(skip_out));
      chk("acc_load", 16'(exp_id != 16'hffff), 16'(acc_load_out));
      if (exp_id != 16'hffff) chk("acc_data", exp_id, acc_data_out);
      chk("halt_end", 16'h0000, 16'(halt_out));
   endtask

   task sc_noop;
      issue(self_check_pkg::VERIFY_OPCODE);
      wait_sig(4);
      chk("nv_skip", 16'h0000, 16'(nv_skip));
      chk("nv_acc", 16'h0000, 16'(nv_acc));
      chk("nv_halt", 16'h0000, 16'(nv_halt));
      do_pass(8, 1'b1, 1'b0);
      wait_sig(1);
   endtask

   task sc_inhibit;
      issue(self_check_pkg::TRAP_INHIBIT_OPCODE);
      wait_sig(1);
      chk("mc_enable_off", 16'h0000, 16'(mc_enable_out));
      machine_check_in = 1'b1;
      repeat (6) @(negedge clk_in);
      chk("halt_inhibited", 16'h0000, 16'(halt_out));
      chk("no_start", 16'h0000, 16'(test_start_out));
      machine_check_in = 1'b0;
      @(negedge clk_in);
      issue(self_check_pkg::TRAP_ENABLE_OPCODE);
      wait_sig(1);
      chk("mc_enable_on", 16'h0001, 16'(mc_enable_out));
   endtask

   task sc_transient;
      @(negedge clk_in);
      machine_check_in = 1'b1;
      wait_sig(0);
      issue(self_check_pkg::TRAP_INHIBIT_OPCODE);
      chk("refused_done", 16'h0000, 16'(instr_done_out));
      @(negedge clk_in);
      chk("refused_done2", 16'h0000, 16'(instr_done_out));
      chk("halt_held", 16'h0001, 16'(halt_out));
      do_pass(8, 1'b1, 1'b1);
      chk("halt_err", 16'h0001, 16'(halt_out));
      // error still standing at pass end forces a rerun
      wait_sig(0);
      machine_check_in = 1'b0;
      do_pass(8, 1'b1, 1'b1);
      wait_sig(2);
      chk("clear_regfile", 16'h0001, 16'(clear_regfile_out));
      @(negedge clk_in);
      chk("irq", 16'h0001, 16'(irq_out));
      wait_sig(3);
      chk("mc_enable_kept", 16'h0001, 16'(mc_enable_out));
   endtask

   task sc_panel_clean;
      int n;
      logic seen;
      seen = 1'b0;
      pulse_panel();
      do_pass(8, 1'b1, 1'b0);
      for (n = 0; n < 20; n++) begin
         if (irq_out === 1'b1) seen = 1'b1;
         @(negedge clk_in);
      end
      chk("panel_irq", 16'h0000, 16'(seen));
      chk("panel_halt", 16'h0000, 16'(halt_out));
   endtask

   task sc_panel_solid;
      pulse_panel();
      do_pass(5, 1'b1, 1'b0);
      wait_sig(0);
      chk("lamps", 16'h0005, panel_lamps_out);
      chk("halt_solid", 16'h0001, 16'(halt_out));
      do_pass(5, 1'b1, 1'b1);
      wait_sig(0);
      chk("lamps2", 16'h0005, panel_lamps_out);
      do_pass(8, 1'b1, 1'b1);
      wait_sig(2);
      @(negedge clk_in);
      chk("irq_solid", 16'h0001, 16'(irq_out));
      wait_sig(3);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(negedge clk_in);
      sys_rst_in = 1'b0;
      sc_reset();
      sc_noop();
      sc_verify(8, 1'b1, 16'hffff);
      sc_verify(3, 1'b1, 16'h0003);
      sc_verify(8, 1'b0, 16'h0007);
      sc_inhibit();
      sc_transient();
      sc_panel_clean();
      sc_panel_solid();
      give_verdict();
   end
endmodule
